// [tb/mrcd_checker.sv]
// concurrent checks on the frame-exchange block ports
`timescale 1ns/1ps
module mrcd_checker (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic rts_rx_end,
  input wire mrcd_pkg::mrcd_rts_rx_t rts_rx,
  input wire logic rts_tx_end,
  input wire logic cts_rx_end,
  input wire logic tx_note_valid,
  input wire mrcd_pkg::mrcd_tx_note_t tx_note,
  input wire logic unit_done,
  input wire logic [2:0] seq_sel,
  input wire logic cts_send,
  input wire logic data_go,
  input wire logic backoff_req,
  input wire logic tx_hold,
  input wire logic [3:0] rcpt_blocked,
  input wire logic [10:0] seq_num
);
  logic [7:0] gap_q, air_q;
  logic [15:0] rx_q, cr_q, tx_q;
  logic cts_q, ref_q;
  wire wr = psel && penable && pready && pwrite;
  wire [15:0] g20 = {8'h00, gap_q} * 16'h0014;
  wire [15:0] ga20 = ({8'h00, gap_q} + {8'h00, air_q}) * 16'h0014;
  // gap shadow and cycles since each event; counts wrap long after any legal wait
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gap_q <= 8'h0a;
      air_q <= 8'h00;
      rx_q <= 16'h0000;
      cr_q <= 16'h0000;
      tx_q <= 16'h0000;
      cts_q <= 1'b0;
      ref_q <= 1'b0;
    end else begin
      if (wr && paddr == 8'h04) gap_q <= pwdata[7:0];
      if (wr && paddr == 8'h08) air_q <= pwdata[7:0];
      rx_q <= rts_rx_end ? 16'h0000 : rx_q + 16'h0001;
      cr_q <= cts_rx_end ? 16'h0000 : cr_q + 16'h0001;
      tx_q <= rts_tx_end ? 16'h0000 : tx_q + 16'h0001;
      cts_q <= cts_rx_end || (cts_q && !rts_tx_end);
      if (rts_rx_end) ref_q <= !rts_rx.in_resv && !rts_rx.vst_zero;
    end
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_unit;
    unit_done && clk_en && !$past(unit_done) && $stable(seq_sel) ##1
      !unit_done && $stable(seq_sel);
  endsequence
  apb_answer_a: assert property (s_setup |=> pready)
    else $error("no ready after setup");
  unmapped_a: assert property (pready && paddr > 8'h28 |-> pslverr)
    else $error("no slave error");
  cts_time_a: assert property (cts_send |-> rx_q + 1 >= g20 && rx_q <= g20 + 2)
    else $error("cts off the gap");
  refuse_a: assert property (ref_q |-> !cts_send)
    else $error("cts with timer busy");
  data_gap_a: assert property (data_go |-> cts_q && cr_q + 1 >= g20 && cr_q <= g20 + 2)
    else $error("protected frame off the gap");
  backoff_a: assert property (backoff_req |-> !cts_q && tx_q + 1 >= ga20 && tx_q <= ga20 + 2)
    else $error("backoff off the timeout");
  hold_quiet_a: assert property (tx_hold |-> !data_go && !backoff_req)
    else $error("send during hold");
  block_rcpt_a: assert property (tx_note_valid && !tx_note.more_frames && tx_note.access_method
    |=> (rcpt_blocked & $past(tx_note.rcpt)) == $past(tx_note.rcpt)) else $error("not held");
  seq_step_a: assert property (s_unit |=> seq_num == $past(seq_num, 2) + 11'h001)
    else $error("sequence step wrong");
endmodule

bind mrcd_core mrcd_checker chk (.pclk, .presetn, .clk_en, .psel, .penable, .pwrite, .paddr,
  .pwdata,
  .pready, .pslverr, .rts_rx_end, .rts_rx, .rts_tx_end, .cts_rx_end, .tx_note_valid, .tx_note,
  .unit_done, .seq_sel, .cts_send, .data_go, .backoff_req, .tx_hold, .rcpt_blocked, .seq_num);

// [tb/mrcd_peer.sv]
// peer device model: its rts to us and its cts to our rts
`timescale 1ns/1ps
module mrcd_peer (
  input wire logic pclk,
  output logic rts_rx_end,
  output mrcd_pkg::mrcd_rts_rx_t rts_rx,
  output logic rts_tx_end,
  output logic rts_tx_contention,
  output logic cts_rx_end
);
  initial begin
    {rts_rx_end, rts_rx, rts_tx_end, rts_tx_contention, cts_rx_end} = '0;
  end
  // descriptor counts only with its pulse; scrambled after so stale values never match
  task automatic send_rts(input logic [2:0] f, input logic [15:0] d);
    @(posedge pclk);
    rts_rx_end <= 1'b1;
    rts_rx <= {f, d};
    @(posedge pclk);
    rts_rx_end <= 1'b0;
    rts_rx <= ~{f, d};
  endtask
  // the cts comes inside gap plus cts airtime when answered, otherwise never
  task automatic rts_exchange(input logic cont, input logic ans, input int w);
    @(posedge pclk);
    rts_tx_end <= 1'b1;
    rts_tx_contention <= cont;
    @(posedge pclk);
    rts_tx_end <= 1'b0;
    rts_tx_contention <= ~cont;
    if (ans) begin
      repeat (w) @(posedge pclk);
      cts_rx_end <= 1'b1;
      @(posedge pclk);
      cts_rx_end <= 1'b0;
    end
  endtask
endmodule

// [tb/testbench.sv]
// self-checking bench for the frame-exchange block
`timescale 1ns/1ps
`include "mrcd_regs.svh"
module testbench;
  localparam int G = 2;
  localparam int A = 1;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic clk_en = 1'b1;
  logic psel, penable, pwrite, in_contention, run_uncovered, in_hard_block, tx_note_valid;
  logic resv_block_end, superframe_tick, unit_done, pready, pslverr, rts_rx_end, rts_tx_end;
  logic rts_tx_contention, cts_rx_end, cts_send, data_go, backoff_req, tx_hold, rts_advise;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [15:0] us_to_boundary, duration;
  logic [3:0] rcpt_exempt, rcpt_blocked;
  logic [2:0] seq_sel;
  logic [10:0] seq_num, beacon_seq;
  mrcd_pkg::mrcd_rts_rx_t rts_rx;
  mrcd_pkg::mrcd_tx_note_t tx_note;
  int failures = 0, checks = 0, cyc = 0, nb = 0, t_rx, t_cr, t_ans, t_dat;
  int n_cts = 0, n_dat = 0, n_bo = 0, n_hold = 0;
  mrcd_core uut (.*);
  mrcd_peer peer (.*);
  always #25 pclk = ~pclk;
  // event log; the ceiling is well past the longest run of about 7000 cycles
  always @(posedge pclk) begin
    cyc++;
    if (rts_rx_end === 1'b1) t_rx = cyc;
    if (cts_rx_end === 1'b1) t_cr = cyc;
    if (cts_send === 1'b1) begin
      n_cts++;
      t_ans = cyc;
    end
    if (data_go === 1'b1) begin
      n_dat++;
      t_dat = cyc;
    end
    n_bo += (backoff_req === 1'b1);
    n_hold += (tx_hold === 1'b1);
    if (cyc == 20000) begin
      failures++;
      summarize();
    end
  end
  task automatic chk(input logic [32:0] g, input logic [32:0] x);
    checks++;
    if (g !== x) begin
      failures++;
      $display("unexpected at %0t: got %h want %h", $time, g, x);
    end
  endtask
  // one apb transfer, held until ready is seen at an edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
      output logic [32:0] r);
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = {pslverr, prdata};
    {psel, penable} <= 2'b00;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [32:0] r;
    apb(1'b1, a, d, r);
  endtask
  task automatic rd(input logic [7:0] a, input logic [32:0] x);
    logic [32:0] r;
    apb(1'b0, a, 32'h0, r);
    chk(r, x);
  endtask
  task automatic t_regs();
    rd(`MRCD_ADDR_CTRL, `MRCD_CTRL_RST);
    rd(`MRCD_ADDR_GAP, `MRCD_GAP_RST);
    rd(`MRCD_ADDR_CTSAIR, `MRCD_CTSAIR_RST);
    wr(8'h2c, 32'h1);
    rd(8'h2c, 33'h100000000);
    wr(`MRCD_ADDR_GAP, G);
    wr(`MRCD_ADDR_CTSAIR, A);
    rd(`MRCD_ADDR_GAP, G);
    $display("registers done");
  endtask
  task automatic t_cts();
    logic [2:0] f [5] = '{3'b110, 3'b001, 3'b000, 3'b001, 3'b001};
    logic e [5] = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b0};
    int d [5] = '{100, 100, 100, 100, 5};
    int b [5] = '{1000, 1000, 1000, 10, 4};
    int n;
    for (int i = 0; i < 5; i++) begin
      n = n_cts;
      us_to_boundary <= 16'(b[i]);
      peer.send_rts(f[i], 16'(d[i]));
      repeat (20 * G + 10) @(posedge pclk);
      chk(n_cts - n, e[i]);
      if (e[i]) chk(t_ans - t_rx inside {[20 * G + 1 : 20 * G + 2]}, 1);
    end
    $display("cts answer done");
  endtask
  task automatic t_src();
    int n, h;
    n = n_dat;
    peer.rts_exchange(1'b1, 1'b1, 20 * (G + A) - 10);
    repeat (20 * G + 10) @(posedge pclk);
    chk(n_dat - n, 1);
    chk(t_dat - t_cr inside {[20 * G + 1 : 20 * G + 2]}, 1);
    n = n_bo;
    peer.rts_exchange(1'b1, 1'b0, 0);
    repeat (20 * (G + A) + 10) @(posedge pclk);
    chk(n_bo - n, 1);
    n = n_bo;
    h = n_hold;
    peer.rts_exchange(1'b0, 1'b0, 0);
    repeat (20 * (2 * G + A) + 10) @(posedge pclk);
    chk(n_bo - n, 0);
    chk(n_hold - h inside {[20 * G - 1 : 20 * G + 2]}, 1);
    $display("source side done");
  endtask
  task automatic t_dur();
    logic [7:0] c [9] = '{8'h02, 8'h02, 8'h02, 8'h0a, 8'h12, 8'h06, 8'h06, 8'h02, 8'h02};
    logic [7:0] t [9] = '{8'h20, 8'h20, 8'h22, 8'h22, 8'h22, 8'h20, 8'h23, 8'h24, 8'h21};
    int x [9] = '{100 + 20 + 300 + 2 * G, 400, 400 - 7, 100, 0, 0, 400 - 7, 100 + G + 20,
                  1000 - G - 100 - 7};
    peer.send_rts(3'b000, 16'd1000);
    wr(`MRCD_ADDR_BODY, 100);
    wr(`MRCD_ADDR_RESP, 20);
    wr(`MRCD_ADDR_FOLLOW, 300);
    wr(`MRCD_ADDR_HDR, 7);
    in_hard_block <= 1'b1;
    for (int i = 0; i < 9; i++) begin
      wr(`MRCD_ADDR_WIN, i == 0 ? 1000 : 400);
      wr(`MRCD_ADDR_CTRL, c[i]);
      wr(`MRCD_ADDR_FTYPE, t[i]);
      rd(`MRCD_ADDR_DUR, x[i]);
      chk(duration, x[i]);
    end
    in_hard_block <= 1'b0;
    $display("duration done");
  endtask
  task automatic note(input logic [5:0] v);
    @(posedge pclk);
    {tx_note_valid, tx_note} <= {1'b1, v};
    @(posedge pclk);
    {tx_note_valid, tx_note} <= {1'b0, ~v};
    repeat (2) @(posedge pclk);
  endtask
  task automatic tick(input logic sf);
    @(posedge pclk);
    {resv_block_end, superframe_tick} <= {!sf, sf};
    nb += sf;
    @(posedge pclk);
    {resv_block_end, superframe_tick} <= 2'b00;
    repeat (2) @(posedge pclk);
  endtask
  task automatic t_more();
    {rcpt_exempt, in_contention, run_uncovered} <= 6'b010011;
    note(6'b010001);
    chk(rcpt_blocked, 4'b0001);
    rd(`MRCD_ADDR_STATUS, 33'h000000100);
    chk(rts_advise, 1'b1);
    run_uncovered <= 1'b0;
    tick(1'b0);
    chk({rcpt_blocked, rts_advise}, 5'b00000);
    note(6'b000110);
    note(6'b101000);
    chk(rcpt_blocked, 4'b0010);
    tick(1'b1);
    chk({rcpt_blocked, beacon_seq}, {4'b0000, 11'(nb)});
    wr(`MRCD_ADDR_CTRL, 32'h3);
    repeat (2) @(posedge pclk);
    chk(beacon_seq, 11'h000);
    $display("more frames done");
  endtask
  task automatic unit(input logic [2:0] s, input int k);
    repeat (k) begin
      @(posedge pclk);
      {seq_sel, unit_done} <= {s, 1'b1};
      @(posedge pclk);
      unit_done <= 1'b0;
      @(posedge pclk);
    end
  endtask
  task automatic show(input logic [2:0] s, input logic [10:0] x);
    seq_sel <= s;
    repeat (3) @(posedge pclk);
    chk(seq_num, x);
  endtask
  task automatic t_seq();
    unit(3'd0, 3);
    unit(3'd1, 1);
    show(3'd1, 11'd1);
    show(3'd0, 11'd3);
    unit(3'd6, 2049);
    clk_en <= 1'b0;
    unit(3'd5, 2);
    clk_en <= 1'b1;
    show(3'd5, 11'd1);
    $display("sequence done");
  endtask
  task automatic summarize();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  initial begin
    {psel, penable, pwrite, paddr, pwdata, in_contention, run_uncovered, in_hard_block} = '0;
    {tx_note_valid, tx_note, rcpt_exempt, resv_block_end, superframe_tick, unit_done} = '0;
    {seq_sel, us_to_boundary} = '0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_cts();
    t_src();
    t_dur();
    t_more();
    t_seq();
    summarize();
  end
endmodule

// [verilog/mrcd_core.sv]
// rts/cts timing, duration arithmetic, more-frames gating and sequence counters
//
// Our own choices: the register addresses and register access over APB.
`timescale 1ns/1ps
`include "mrcd_regs.svh"

module mrcd_core (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic rts_rx_end,
  input wire mrcd_pkg::mrcd_rts_rx_t rts_rx,
  input wire logic [15:0] us_to_boundary,
  input wire logic rts_tx_end,
  input wire logic rts_tx_contention,
  input wire logic cts_rx_end,
  input wire logic in_contention,
  input wire logic run_uncovered,
  input wire logic in_hard_block,
  input wire logic tx_note_valid,
  input wire mrcd_pkg::mrcd_tx_note_t tx_note,
  input wire logic [3:0] rcpt_exempt,
  input wire logic resv_block_end,
  input wire logic superframe_tick,
  input wire logic unit_done,
  input wire logic [2:0] seq_sel,
  output logic cts_send,
  output logic data_go,
  output logic backoff_req,
  output logic tx_hold,
  output logic rts_advise,
  output logic [3:0] rcpt_blocked,
  output logic [15:0] duration,
  output logic [10:0] seq_num,
  output logic [10:0] beacon_seq
);

  // software-visible state
  logic [7:0] ctrl_q;
  logic [7:0] gap_q;
  logic [15:0] cts_air_q;
  logic [15:0] body_q;
  logic [15:0] resp_q;
  logic [15:0] follow_q;
  logic [15:0] hdr_q;
  logic [15:0] win_q;
  logic [7:0] ftype_q;

  // bus interface flops
  logic [31:0] prdata_q;
  logic pready_q;
  logic pslverr_q;

  // handshake state
  mrcd_pkg::mrcd_state_t state_q;
  mrcd_pkg::mrcd_state_t state_d;
  logic [15:0] tmr_q;
  logic [15:0] tmr_d;
  logic [4:0] pre_q;
  logic cts_send_q;
  logic data_go_q;
  logic backoff_q;
  logic hold_q;
  logic advise_q;
  logic [15:0] dur_q;
  logic [15:0] rx_dur_q;
  logic [3:0] blk_resv_q;
  logic [3:0] blk_pca_q;
  logic [3:0] blk_out_q;
  logic [10:0] seq_q [`MRCD_NSEQ];
  logic [10:0] seq_out_q;
  logic [10:0] bcn_out_q;

  // apb decode, zero wait: ready is raised on the setup cycle
  wire setup = psel & ~penable;
  wire wr_en = psel & penable & pready_q & pwrite;
  wire a_ctrl = (paddr == `MRCD_ADDR_CTRL);
  wire a_gap = (paddr == `MRCD_ADDR_GAP);
  wire a_cts = (paddr == `MRCD_ADDR_CTSAIR);
  wire a_body = (paddr == `MRCD_ADDR_BODY);
  wire a_resp = (paddr == `MRCD_ADDR_RESP);
  wire a_fol = (paddr == `MRCD_ADDR_FOLLOW);
  wire a_hdr = (paddr == `MRCD_ADDR_HDR);
  wire a_win = (paddr == `MRCD_ADDR_WIN);
  wire a_ft = (paddr == `MRCD_ADDR_FTYPE);
  wire a_dur = (paddr == `MRCD_ADDR_DUR);
  wire a_sts = (paddr == `MRCD_ADDR_STATUS);
  wire mapped = a_ctrl | a_gap | a_cts | a_body | a_resp | a_fol |
                a_hdr | a_win | a_ft | a_dur | a_sts;
  wire [31:0] status_w = {16'h0000, 1'b0, state_q, rcpt_blocked, 4'h0, 1'b0,
                          hold_q, backoff_q, cts_send_q};
  wire [31:0] rd_mux;

  // read mux: unmapped reads return zero with an error
  assign rd_mux = a_ctrl ? {24'h000000, ctrl_q} :
                  a_gap ? {24'h000000, gap_q} :
                  a_cts ? {16'h0000, cts_air_q} :
                  a_body ? {16'h0000, body_q} :
                  a_resp ? {16'h0000, resp_q} :
                  a_fol ? {16'h0000, follow_q} :
                  a_hdr ? {16'h0000, hdr_q} :
                  a_win ? {16'h0000, win_q} :
                  a_ft ? {24'h000000, ftype_q} :
                  a_dur ? {16'h0000, dur_q} :
                  a_sts ? status_w : 32'h00000000;

  // answer flops, set on the setup cycle for one access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h00000000;
    end else if (clk_en) begin
      pready_q <= setup;
      pslverr_q <= setup & ~mapped;
      prdata_q <= (setup & ~pwrite) ? rd_mux : 32'h00000000;
    end
  end

  // register writes, taken only at the completing access edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= `MRCD_CTRL_RST;
      gap_q <= `MRCD_GAP_RST;
      cts_air_q <= `MRCD_CTSAIR_RST;
      body_q <= 16'h0000;
      resp_q <= 16'h0000;
      follow_q <= 16'h0000;
      hdr_q <= 16'h0000;
      win_q <= 16'h0000;
      ftype_q <= 8'h00;
    end else if (clk_en && wr_en) begin
      if (a_ctrl) ctrl_q <= pwdata[7:0];
      else if (a_gap) gap_q <= pwdata[7:0];
      else if (a_cts) cts_air_q <= pwdata[15:0];
      else if (a_body) body_q <= pwdata[15:0];
      else if (a_resp) resp_q <= pwdata[15:0];
      else if (a_fol) follow_q <= pwdata[15:0];
      else if (a_hdr) hdr_q <= pwdata[15:0];
      else if (a_win) win_q <= pwdata[15:0];
      else if (a_ft) ftype_q <= pwdata[7:0];
    end
  end

  // cts admission: wide sums so the fit test never wraps
  wire [17:0] cts_need = {10'h000, gap_q} + {2'b00, cts_air_q} + {10'h000, gap_q};
  wire cts_fits = cts_need <= {2'b00, us_to_boundary};
  wire [17:0] dur_reach = {2'b00, rts_rx.dur} + {10'h000, gap_q};
  wire overrun = dur_reach > {2'b00, us_to_boundary};
  wire owner_rts = rts_rx.in_resv & rts_rx.from_owner;
  wire free_rts = ~rts_rx.in_resv & rts_rx.vst_zero & cts_fits &
                  ~(ctrl_q[`MRCD_CTRL_WITHHOLD] & overrun);
  wire answer_rts = rts_rx_end & (owner_rts | free_rts);
  wire tick = (pre_q == 5'(`MRCD_CYC_PER_US - 1));
  wire tmr_zero = (tmr_q == 16'h0000);
  wire [15:0] wait_cts = 16'(cts_need - {10'h000, gap_q});
  logic contention_q;

  // the descriptor stands only with its pulse, so the duration it carries is kept
  // for the responder arithmetic long after the peer has moved on
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) rx_dur_q <= 16'h0000;
    else if (clk_en && rts_rx_end) rx_dur_q <= rts_rx.dur;
  end

  // handshake next state; the timer counts whole microseconds
  // only one exchange is tracked; events that arrive mid-exchange are dropped
  always_comb begin
    state_d = state_q;
    tmr_d = (tick && !tmr_zero) ? tmr_q - 16'h0001 : tmr_q;
    case (state_q)
      mrcd_pkg::st_idle: begin
        if (answer_rts) begin
          state_d = mrcd_pkg::st_resp;
          tmr_d = {8'h00, gap_q};
        end else if (rts_tx_end) begin
          state_d = mrcd_pkg::st_wait_cts;
          tmr_d = wait_cts;
        end
      end
      mrcd_pkg::st_resp: begin
        if (tmr_zero) state_d = mrcd_pkg::st_idle;
      end
      mrcd_pkg::st_wait_cts: begin
        if (cts_rx_end) begin
          state_d = mrcd_pkg::st_gap;
          tmr_d = {8'h00, gap_q};
        end else if (tmr_zero && contention_q) begin
          state_d = mrcd_pkg::st_idle;
        end else if (tmr_zero) begin
          state_d = mrcd_pkg::st_hold;
          tmr_d = {8'h00, gap_q};
        end
      end
      mrcd_pkg::st_gap: begin
        if (tmr_zero) state_d = mrcd_pkg::st_idle;
      end
      mrcd_pkg::st_hold: begin
        if (tmr_zero) state_d = mrcd_pkg::st_idle;
      end
      default: state_d = mrcd_pkg::st_idle;
    endcase
  end

  // prescaler restarts on every load so a wait is never a microsecond short
  wire load = (state_d != state_q);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= mrcd_pkg::st_idle;
      tmr_q <= 16'h0000;
      pre_q <= 5'h00;
      contention_q <= 1'b0;
    end else if (clk_en) begin
      state_q <= state_d;
      tmr_q <= tmr_d;
      pre_q <= (load || tick) ? 5'h00 : pre_q + 5'h01;
      if (state_q == mrcd_pkg::st_idle && rts_tx_end) contention_q <= rts_tx_contention;
    end
  end

  // one-cycle action pulses and the hold-off level
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cts_send_q <= 1'b0;
      data_go_q <= 1'b0;
      backoff_q <= 1'b0;
      hold_q <= 1'b0;
      advise_q <= 1'b0;
    end else if (clk_en) begin
      cts_send_q <= (state_q == mrcd_pkg::st_resp) & tmr_zero;
      data_go_q <= (state_q == mrcd_pkg::st_gap) & tmr_zero;
      backoff_q <= (state_q == mrcd_pkg::st_wait_cts) & ~cts_rx_end &
                   tmr_zero & contention_q;
      hold_q <= (state_d == mrcd_pkg::st_hold);
      advise_q <= in_contention & run_uncovered;
    end
  end

  // duration terms in whole microseconds, saturating at both ends; the inputs
  // are trusted to be whole microseconds, so rounding is the caller's budget
  wire [3:0] nifs = ftype_q[`MRCD_FT_NIFS_HI:`MRCD_FT_NIFS_LO];
  // widen both factors first: fifteen gaps of 255 us need all twelve bits
  wire [11:0] ifs_sum = {4'h0, gap_q} * {8'h00, nifs};
  wire [18:0] data_sum = {3'b000, body_q} + {3'b000, resp_q} +
                         {3'b000, follow_q} + {7'h00, ifs_sum};
  wire [18:0] data_cap = (data_sum > {3'b000, win_q}) ? {3'b000, win_q} : data_sum;
  wire [18:0] rsp_sub = {11'h000, gap_q} + {3'b000, body_q} + {3'b000, hdr_q};
  wire [18:0] rsp_dur = ({3'b000, rx_dur_q} > rsp_sub) ?
                        {3'b000, rx_dur_q} - rsp_sub : 19'h00000;
  wire [18:0] bar_sum = {3'b000, body_q} + {11'h000, gap_q} + {3'b000, resp_q};
  wire [18:0] rel_dur = (win_q > hdr_q) ? {3'b000, win_q - hdr_q} : 19'h00000;
  wire [1:0] bmode = ctrl_q[`MRCD_CTRL_BMODE_HI:`MRCD_CTRL_BMODE_LO];
  wire [18:0] bcn_dur = (bmode == 2'h0) ? rel_dur :
                        (bmode == 2'h1) ? {3'b000, body_q} : 19'h00000;
  wire [2:0] ft = ftype_q[`MRCD_FT_HI:`MRCD_FT_LO];
  wire hard_zero = ctrl_q[`MRCD_CTRL_HARD_ZERO] & in_hard_block &
                   (ft != 3'(mrcd_pkg::ft_release));
  wire [18:0] dur_sel = hard_zero ? 19'h00000 :
                        (ft == 3'(mrcd_pkg::ft_data)) ? data_cap :
                        (ft == 3'(mrcd_pkg::ft_resp)) ? rsp_dur :
                        (ft == 3'(mrcd_pkg::ft_beacon)) ? bcn_dur :
                        (ft == 3'(mrcd_pkg::ft_release)) ? rel_dur :
                        (ft == 3'(mrcd_pkg::ft_bar)) ? bar_sum : 19'h00000;
  wire [15:0] dur_sat = (dur_sel > 19'h0ffff) ? 16'hffff : dur_sel[15:0];

  // duration result flop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) dur_q <= 16'h0000;
    else if (clk_en) dur_q <= dur_sat;
  end

  // per-recipient send gates; a block end lifts the reservation ones and a superframe the others, but a block
  // in the same cycle wins so a last frame at the boundary is never forgotten
  wire [3:0] blk_resv_d;
  wire [3:0] blk_pca_d;
  genvar gi;
  generate
    for (gi = 0; gi < `MRCD_NRCPT; gi = gi + 1) begin : g_rcpt
      wire hit = tx_note_valid & ~tx_note.more_frames & tx_note.rcpt[gi];
      wire pca_hit = hit & ~tx_note.access_method & ~rcpt_exempt[gi];
      assign blk_resv_d[gi] = (hit & tx_note.access_method) |
                              (blk_resv_q[gi] & ~resv_block_end);
      assign blk_pca_d[gi] = pca_hit | (blk_pca_q[gi] & ~superframe_tick);
    end
  endgenerate

  // the combined gate has a flop of its own so the output never comes from an or
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      blk_resv_q <= 4'h0;
      blk_pca_q <= 4'h0;
      blk_out_q <= 4'h0;
    end else if (clk_en) begin
      blk_resv_q <= blk_resv_d;
      blk_pca_q <= blk_pca_d;
      blk_out_q <= blk_resv_d | blk_pca_d;
    end
  end

  // selector codes 6 and 7 fall into the shared counter, so a stray code still
  // numbers its units instead of losing them
  wire [2:0] sel_ok = (seq_sel < 3'(`MRCD_SEQ_BCN)) ? seq_sel : 3'h5;

  // counters: 0 command, 1-4 block-ack streams, 5 shared, 6 beacon
  generate
    for (gi = 0; gi < `MRCD_NSEQ; gi = gi + 1) begin : g_seq
      wire bump = (gi == `MRCD_SEQ_BCN) ? superframe_tick :
                  (unit_done && sel_ok == 3'(gi));
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) seq_q[gi] <= 11'h000;
        else if (clk_en && bump) seq_q[gi] <= seq_q[gi] + 11'h001;
      end
    end
  endgenerate

  // the number shown stays fixed across fragments until unit_done
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      seq_out_q <= 11'h000;
      bcn_out_q <= 11'h000;
    end else if (clk_en) begin
      seq_out_q <= seq_q[sel_ok];
      bcn_out_q <= ctrl_q[`MRCD_CTRL_BCN_SEQ_ZERO] ? 11'h000 : seq_q[`MRCD_SEQ_BCN];
    end
  end

  // outputs straight from flops
  // nothing here is combined after the flops, so no output glitches
  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign cts_send = cts_send_q;
  assign data_go = data_go_q;
  assign backoff_req = backoff_q;
  assign tx_hold = hold_q;
  assign rts_advise = advise_q;
  assign rcpt_blocked = blk_out_q;
  assign duration = dur_q;
  assign seq_num = seq_out_q;
  assign beacon_seq = bcn_out_q;

endmodule

// [verilog/mrcd_pkg.sv]
// types shared by the frame-exchange block
package mrcd_pkg;
  typedef enum logic [2:0] {
    st_idle, st_resp, st_wait_cts, st_gap, st_hold
  } mrcd_state_t;

  typedef enum logic [2:0] {
    ft_data, ft_resp, ft_beacon, ft_release, ft_bar
  } mrcd_ftype_t;

  // received rts description, valid with its end pulse
  typedef struct packed {
    logic in_resv;
    logic from_owner;
    logic vst_zero;
    logic [15:0] dur;
  } mrcd_rts_rx_t;

  // sent frame summary for more-frames tracking
  typedef struct packed {
    logic more_frames;
    logic access_method;
    logic [3:0] rcpt;
  } mrcd_tx_note_t;
endpackage

// [verilog/mrcd_regs.svh]
// register map, field positions, reset values and timing counts
`ifndef MRCD_REGS_SVH
`define MRCD_REGS_SVH

// apb byte addresses
`define MRCD_ADDR_CTRL 8'h00
`define MRCD_ADDR_GAP 8'h04
`define MRCD_ADDR_CTSAIR 8'h08
`define MRCD_ADDR_BODY 8'h0c
`define MRCD_ADDR_RESP 8'h10
`define MRCD_ADDR_FOLLOW 8'h14
`define MRCD_ADDR_HDR 8'h18
`define MRCD_ADDR_WIN 8'h1c
`define MRCD_ADDR_FTYPE 8'h20
`define MRCD_ADDR_DUR 8'h24
`define MRCD_ADDR_STATUS 8'h28

// control register fields
`define MRCD_CTRL_BCN_SEQ_ZERO 0
`define MRCD_CTRL_WITHHOLD 1
`define MRCD_CTRL_HARD_ZERO 2
`define MRCD_CTRL_BMODE_LO 3
`define MRCD_CTRL_BMODE_HI 4
// frame type register fields
`define MRCD_FT_LO 0
`define MRCD_FT_HI 2
`define MRCD_FT_NIFS_LO 4
`define MRCD_FT_NIFS_HI 7

// reset values
`define MRCD_CTRL_RST 8'h02
`define MRCD_GAP_RST 8'h0a
`define MRCD_CTSAIR_RST 16'h0000

// timing: microsecond tick from the bus clock
`define MRCD_CLK_PERIOD_NS 50
`define MRCD_US_NS 1000
`define MRCD_CYC_PER_US (`MRCD_US_NS / `MRCD_CLK_PERIOD_NS)

// sequence numbers wrap at 2048
`define MRCD_SEQ_W 11
`define MRCD_NRCPT 4
`define MRCD_NSEQ 7
`define MRCD_SEQ_BCN 6

`endif
